/* File: btoc_clamp.sv */
// saturation of one requested trim offset to its limits
module btoc_clamp #(
   parameter int W = 32
) (
   // requested value, one bit wider than the store
   input wire logic signed [W:0] val_in,
   // limits
   input wire logic signed [W-1:0] lo_in,
   input wire logic signed [W-1:0] hi_in,
   // result
   output logic signed [W-1:0] res_out,
   output logic hit_out
);

   // =====================================================================
   // low limit wins when both limits are crossed
   always_comb begin
      if (val_in < lo_in) begin
         res_out = lo_in;
         hit_out = 1'b1;
      end else if (val_in > hi_in) begin
         res_out = hi_in;
         hit_out = 1'b1;
      end else begin
         res_out = W'(val_in);
         hit_out = 1'b0;
      end
   end

endmodule

/* File: btoc_cmd.sv */
// bias trim offset command interpreter with avalon-mm registers
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`include "btoc_consts.svh"

module btoc_cmd import btoc_pkg::*; #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // avalon-mm slave
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // command bytes from the serial receiver
   input wire logic [7:0] rx_data_in,
   input wire logic rx_valid_in,
   output logic rx_ready_out,
   // response bytes to the serial transmitter
   output logic [7:0] tx_data_out,
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   // interrupt
   output logic irq_out
);

   localparam logic [135:0] HDR = `BTOC_HDR_TXT;

   btoc_state_type ps;
   btoc_rsp_type rph;
   logic ctrl_en;
   logic [2:0] st;
   logic [2:0] ien;
   logic [3:0] lerr;
   logic [31:0] ref_tag;
   logic [W-1:0] lim_lo [3];
   logic [W-1:0] lim_hi [3];
   logic [W-1:0] trim [`BTOC_NUM_AXES];
   logic [W-1:0] num;
   logic neg;
   logic dig;
   logic have;
   logic [1:0] nargs;
   logic [7:0] sel1;
   logic [7:0] sel2;
   logic [3:0] err;
   logic [8:0] mask_q;
   logic rref;
   logic [3:0] ridx;
   logic [4:0] rpos;
   logic take;
   logic [7:0] c;
   logic is_digit;
   logic acc;
   logic wr;
   logic [31:0] rdata;

   assign take = rx_valid_in & rx_ready_out;
   assign c = rx_data_in;
   assign is_digit = (c >= `BTOC_CH_ZERO) && (c <= `BTOC_CH_NINE);
   assign acc = (avs_read_in | avs_write_in) & avs_waitrequest_out;
   assign wr = avs_write_in & ~avs_waitrequest_out;

   // =====================================================================
   // argument decode
   logic [1:0] sens;
   logic [1:0] axis;
   logic sok;
   logic aok;
   logic [8:0] mask;
   logic add;
   logic is_ref;
   logic [3:0] eerr;
   logic [3:0] fin_err;
   logic [W-1:0] sval;
   logic [3:0] one_idx;
   logic [8:0] hit;
   logic apply;
   logic [W-1:0] res [`BTOC_NUM_AXES];

   always_comb begin
      sens = 2'd0;
      sok = 1'b1;
      unique case (sel1)
         `BTOC_CH_GYRO: sens = 2'd0;
         `BTOC_CH_ACC: sens = 2'd1;
         `BTOC_CH_INC: sens = 2'd2;
         default: sok = 1'b0;
      endcase
      axis = 2'd0;
      aok = 1'b1;
      unique case (sel2)
         `BTOC_CH_X: axis = 2'd0;
         `BTOC_CH_Y: axis = 2'd1;
         `BTOC_CH_Z: axis = 2'd2;
         default: aok = 1'b0;
      endcase
   end

   assign one_idx = 4'({sens, 1'b0}) + 4'(sens) + 4'(axis);
   // raw value in the selected sensor's own unit
   assign sval = neg ? W'(-num) : num;

   always_comb begin
      mask = 9'h000;
      add = 1'b0;
      is_ref = 1'b0;
      eerr = `BTOC_E_NONE;
      if (nargs == 2'd1) begin
         mask = 9'h1ff;
      end else if (nargs == 2'd2 && sel1 == `BTOC_CH_REF) begin
         if (neg) begin
            eerr = `BTOC_E_PARAM;
         end else begin
            is_ref = 1'b1;
         end
      end else if (nargs == 2'd2 && sok) begin
         mask = (sens == 2'd0) ? 9'h007 : (sens == 2'd1) ? 9'h038 : 9'h1c0;
      end else if (nargs == 2'd3 && sok && aok) begin
         mask = 9'(9'h001 << one_idx);
         add = 1'b1;
      end else begin
         eerr = `BTOC_E_PARAM;
      end
   end

   // =====================================================================
   // per-axis update with saturation
   genvar gi;
   generate
      for (gi = 0; gi < `BTOC_NUM_AXES; gi++) begin : g_axis
         logic [W:0] cand;
         assign cand = add ? ({trim[gi][W-1], trim[gi]} + {sval[W-1], sval})
                           : {sval[W-1], sval};
         btoc_clamp #(.W(W)) u_clamp (
            .val_in(cand),
            .lo_in(lim_lo[gi / 3]),
            .hi_in(lim_hi[gi / 3]),
            .res_out(res[gi]),
            .hit_out(hit[gi])
         );
      end
   endgenerate

   assign apply = (ps == PS_EXEC) && (err == `BTOC_E_NONE) && (eerr == `BTOC_E_NONE);
   assign fin_err = (err != `BTOC_E_NONE) ? err :
                    (eerr != `BTOC_E_NONE) ? eerr :
                    (|(hit & mask)) ? `BTOC_E_CLAMP : `BTOC_E_NONE;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int k = 0; k < `BTOC_NUM_AXES; k++) begin
            trim[k] <= '0;
         end
         ref_tag <= 32'h00000000;
      end else if (apply) begin
         for (int k = 0; k < `BTOC_NUM_AXES; k++) begin
            if (mask[k]) begin
               trim[k] <= res[k];
            end
         end
         if (is_ref) begin
            ref_tag <= 32'(num);
         end
      end
   end

   // =====================================================================
   // command parser
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ps <= PS_CMD;
         num <= '0;
         neg <= 1'b0;
         dig <= 1'b0;
         have <= 1'b0;
         nargs <= 2'd0;
         sel1 <= 8'h00;
         sel2 <= 8'h00;
         err <= `BTOC_E_NONE;
      end else if (ps == PS_EXEC) begin
         ps <= PS_RSP;
         err <= fin_err;
      end else if (ps == PS_RSP) begin
         if (rph == RS_DONE && !tx_valid_out) begin
            ps <= PS_CMD;
            err <= `BTOC_E_NONE;
         end
      end else if (take) begin
         unique case (ps)
            PS_CMD: begin
               if (c == `BTOC_CH_CMD) begin
                  ps <= PS_SP;
               end else if (c != `BTOC_CH_CR) begin
                  err <= `BTOC_E_UNKNOWN;
                  ps <= PS_SKIP;
               end
            end
            PS_SP: begin
               num <= '0;
               neg <= 1'b0;
               dig <= 1'b0;
               have <= 1'b0;
               nargs <= 2'd1;
               sel1 <= 8'h00;
               sel2 <= 8'h00;
               if (c == `BTOC_CH_SP) begin
                  ps <= PS_NUM;
               end else if (c == `BTOC_CH_CR) begin
                  err <= `BTOC_E_NARGS;
                  ps <= PS_EXEC;
               end else begin
                  err <= (c == `BTOC_CH_COMMA) ? `BTOC_E_NARGS : `BTOC_E_UNKNOWN;
                  ps <= PS_SKIP;
               end
            end
            PS_NUM: begin
               if (is_digit) begin
                  num <= W'(num * W'(10) + W'(c[3:0]));
                  dig <= 1'b1;
               end else if (c == `BTOC_CH_MINUS && !dig && !neg) begin
                  neg <= 1'b1;
               end else if ((c == `BTOC_CH_COMMA || c == `BTOC_CH_CR) && !dig) begin
                  err <= `BTOC_E_NARGS;
                  ps <= (c == `BTOC_CH_CR) ? PS_EXEC : PS_SKIP;
               end else if (c == `BTOC_CH_COMMA) begin
                  nargs <= 2'd2;
                  ps <= PS_SEL;
               end else if (c == `BTOC_CH_CR) begin
                  ps <= PS_EXEC;
               end else begin
                  err <= `BTOC_E_PARAM;
                  ps <= PS_SKIP;
               end
            end
            PS_SEL: begin
               if ((c == `BTOC_CH_CR || c == `BTOC_CH_COMMA) && !have) begin
                  err <= `BTOC_E_NARGS;
                  ps <= (c == `BTOC_CH_CR) ? PS_EXEC : PS_SKIP;
               end else if (c == `BTOC_CH_CR) begin
                  ps <= PS_EXEC;
               end else if (c == `BTOC_CH_COMMA) begin
                  nargs <= 2'd3;
                  have <= 1'b0;
                  ps <= PS_AXIS;
               end else if (have) begin
                  err <= `BTOC_E_PARAM;
                  ps <= PS_SKIP;
               end else begin
                  sel1 <= c;
                  have <= 1'b1;
               end
            end
            PS_AXIS: begin
               if (c == `BTOC_CH_CR) begin
                  err <= have ? `BTOC_E_NONE : `BTOC_E_NARGS;
                  ps <= PS_EXEC;
               end else if (c == `BTOC_CH_COMMA) begin
                  err <= `BTOC_E_NARGS;
                  ps <= PS_SKIP;
               end else if (have) begin
                  err <= `BTOC_E_PARAM;
                  ps <= PS_SKIP;
               end else begin
                  sel2 <= c;
                  have <= 1'b1;
               end
            end
            PS_SKIP: begin
               if (c == `BTOC_CH_CR) begin
                  ps <= PS_EXEC;
               end
            end
            default: ;
         endcase
      end
   end

   // receiver is held off while executing or answering
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_ready_out <= 1'b0;
      end else begin
         rx_ready_out <= ctrl_en && ps != PS_EXEC && ps != PS_RSP &&
                         !(take && c == `BTOC_CH_CR && ps != PS_CMD);
      end
   end

   // =====================================================================
   // response text
   logic slot;
   logic emit;
   logic [7:0] ch;
   logic [31:0] lval;
   logic [1:0] lsens;
   logic [1:0] laxis;
   logic [7:0] c0;
   logic [7:0] c1;
   logic [3:0] nib;

   assign slot = (ps == PS_RSP) && (!tx_valid_out || tx_ready_in);
   assign lsens = (ridx >= 4'd6) ? 2'd2 : (ridx >= 4'd3) ? 2'd1 : 2'd0;
   assign laxis = 2'(ridx - 4'({lsens, 1'b0}) - 4'(lsens));
   assign lval = (ridx == `BTOC_REF_IDX) ? ref_tag : 32'(trim[ridx < 4'd9 ? ridx : 4'd0]);
   assign nib = 4'(lval >> {(`BTOC_HEX_LAST - rpos), 2'b00});

   always_comb begin
      c0 = `BTOC_CH_REF;
      c1 = `BTOC_CH_REF2;
      if (ridx != `BTOC_REF_IDX) begin
         c0 = (lsens == 2'd0) ? `BTOC_CH_GYRO : (lsens == 2'd1) ? `BTOC_CH_ACC : `BTOC_CH_INC;
         c1 = (laxis == 2'd0) ? `BTOC_CH_X : (laxis == 2'd1) ? `BTOC_CH_Y : `BTOC_CH_Z;
      end
   end

   always_comb begin
      emit = 1'b0;
      ch = `BTOC_CH_SP;
      unique case (rph)
         RS_HDR: begin
            emit = 1'b1;
            if (rpos < `BTOC_HDR_LEN) begin
               ch = 8'(HDR >> {(5'd16 - rpos), 3'b000});
            end else begin
               ch = (rpos == `BTOC_HDR_LEN) ? `BTOC_CH_CR : `BTOC_CH_LF;
            end
         end
         RS_LINE: begin
            emit = (ridx == `BTOC_REF_IDX) ? rref : mask_q[ridx < 4'd9 ? ridx : 4'd0];
            if (rpos == 5'd0) begin
               ch = c0;
            end else if (rpos == 5'd1) begin
               ch = c1;
            end else if (rpos == 5'd3) begin
               ch = `BTOC_CH_EQ;
            end else if (rpos == 5'd13) begin
               ch = `BTOC_CH_CR;
            end else if (rpos == `BTOC_LINE_LAST) begin
               ch = `BTOC_CH_LF;
            end else if (rpos >= 5'd5) begin
               ch = (nib < 4'ha) ? `BTOC_CH_ZERO + 8'(nib) : `BTOC_CH_HEXA + 8'(nib);
            end
         end
         RS_ERR: begin
            emit = (err != `BTOC_E_NONE);
            unique case (rpos)
               5'd0: ch = `BTOC_CH_E;
               5'd1, 5'd2: ch = `BTOC_CH_ZERO;
               5'd3: ch = `BTOC_CH_ZERO + 8'(err);
               5'd4: ch = `BTOC_CH_CR;
               default: ch = `BTOC_CH_LF;
            endcase
         end
         RS_PROMPT: begin
            emit = 1'b1;
            ch = `BTOC_CH_PROMPT;
         end
         default: ;
      endcase
   end

   // header, one line per changed axis or tag, error line, prompt
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rph <= RS_DONE;
         ridx <= 4'd0;
         rpos <= 5'd0;
         mask_q <= 9'h000;
         rref <= 1'b0;
      end else if (ps == PS_EXEC) begin
         rph <= (err != `BTOC_E_NONE || eerr != `BTOC_E_NONE) ? RS_ERR : RS_HDR;
         ridx <= 4'd0;
         rpos <= 5'd0;
         mask_q <= mask;
         rref <= is_ref;
      end else if (slot) begin
         unique case (rph)
            RS_HDR: begin
               rpos <= (rpos == `BTOC_HDR_LAST) ? 5'd0 : rpos + 5'd1;
               rph <= (rpos == `BTOC_HDR_LAST) ? RS_LINE : RS_HDR;
            end
            RS_LINE: begin
               if (!emit) begin
                  ridx <= ridx + 4'd1;
                  rph <= (ridx == `BTOC_REF_IDX) ? RS_ERR : RS_LINE;
               end else if (rpos == `BTOC_LINE_LAST) begin
                  rpos <= 5'd0;
                  ridx <= ridx + 4'd1;
                  rph <= (ridx == `BTOC_REF_IDX) ? RS_ERR : RS_LINE;
               end else begin
                  rpos <= rpos + 5'd1;
               end
            end
            RS_ERR: begin
               rpos <= (!emit || rpos == `BTOC_ERR_LAST) ? 5'd0 : rpos + 5'd1;
               rph <= (!emit || rpos == `BTOC_ERR_LAST) ? RS_PROMPT : RS_ERR;
            end
            RS_PROMPT: rph <= RS_DONE;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tx_valid_out <= 1'b0;
         tx_data_out <= 8'h00;
      end else if (slot && emit) begin
         tx_valid_out <= 1'b1;
         tx_data_out <= ch;
      end else if (tx_ready_in) begin
         tx_valid_out <= 1'b0;
      end
   end

   // =====================================================================
   // register bus
   always_comb begin
      rdata = 32'h00000000;
      unique case (avs_address_in)
         `BTOC_OFS_CTRL: rdata = {31'h0, ctrl_en};
         `BTOC_OFS_STAT: rdata = {29'h0, st};
         `BTOC_OFS_IEN: rdata = {29'h0, ien};
         `BTOC_OFS_REF: rdata = ref_tag;
         `BTOC_OFS_LERR: rdata = {28'h0, lerr};
         default: begin
            if (avs_address_in[7:4] == `BTOC_OFS_LO_BASE && avs_address_in[3:2] != 2'd3) begin
               rdata = 32'(lim_lo[avs_address_in[3:2]]);
            end else if (avs_address_in[7:4] == `BTOC_OFS_HI_BASE &&
                         avs_address_in[3:2] != 2'd3) begin
               rdata = 32'(lim_hi[avs_address_in[3:2]]);
            end else if (avs_address_in[7:6] == `BTOC_OFS_TRIM_BASE &&
                         avs_address_in[5:2] < 4'd9 && avs_address_in[1:0] == 2'd0) begin
               rdata = 32'(trim[avs_address_in[5:2]]);
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h00000000;
      end else begin
         avs_waitrequest_out <= !acc;
         if (acc && avs_read_in) begin
            avs_readdata_out <= rdata;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_en <= `BTOC_CTRL_RST;
         ien <= 3'h0;
         for (int k = 0; k < 3; k++) begin
            lim_lo[k] <= W'(`BTOC_LIM_LO_RST);
            lim_hi[k] <= W'(`BTOC_LIM_HI_RST);
         end
      end else if (wr) begin
         if (avs_address_in == `BTOC_OFS_CTRL) begin
            ctrl_en <= avs_writedata_in[`BTOC_CTRL_EN_BIT];
         end
         if (avs_address_in == `BTOC_OFS_IEN) begin
            ien <= avs_writedata_in[2:0];
         end
         if (avs_address_in[7:4] == `BTOC_OFS_LO_BASE && avs_address_in[3:2] != 2'd3) begin
            lim_lo[avs_address_in[3:2]] <= W'(avs_writedata_in);
         end
         if (avs_address_in[7:4] == `BTOC_OFS_HI_BASE && avs_address_in[3:2] != 2'd3) begin
            lim_hi[avs_address_in[3:2]] <= W'(avs_writedata_in);
         end
      end
   end

   // =====================================================================
   // events and interrupt, set wins over clear
   logic [2:0] st_set;
   logic [2:0] st_clr;

   always_comb begin
      st_set = 3'h0;
      if (ps == PS_EXEC) begin
         st_set[`BTOC_ST_DONE_BIT] = 1'b1;
         st_set[`BTOC_ST_CLAMP_BIT] = (fin_err == `BTOC_E_CLAMP);
         st_set[`BTOC_ST_ERR_BIT] = (fin_err != `BTOC_E_NONE) && (fin_err != `BTOC_E_CLAMP);
      end
   end
   assign st_clr = (wr && avs_address_in == `BTOC_OFS_CLR) ? avs_writedata_in[2:0] : 3'h0;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st <= 3'h0;
         lerr <= `BTOC_E_NONE;
         irq_out <= 1'b0;
      end else begin
         st <= (st & ~st_clr) | st_set;
         if (ps == PS_EXEC) begin
            lerr <= fin_err;
         end
         irq_out <= |(st & ien);
      end
   end

endmodule

/* File: btoc_cmd_props.sv */
// assertion checker for the bias trim offset command handler
module btoc_cmd_props (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // register bus
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // command and response bytes
   input wire logic [7:0] rx_data_in,
   input wire logic rx_valid_in,
   input wire logic rx_ready_out,
   input wire logic [7:0] tx_data_out,
   input wire logic tx_valid_out,
   input wire logic tx_ready_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ===
   // helpers
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   logic fresh;
   // set by a taken line end, cleared by the first reply byte
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         fresh <= 1'b0;
      end else if (rx_valid_in && rx_ready_out && rx_data_in == 8'h0d) begin
         fresh <= 1'b1;
      end else if (tx_valid_out && tx_ready_in) begin
         fresh <= 1'b0;
      end
   end
   // ===
   // properties
   property p_ack;
      (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
   endproperty
   a_ack: assert property (p_ack) else $error("access not answered");
   property p_one;
      !avs_waitrequest_out |=> avs_waitrequest_out;
   endproperty
   a_one: assert property (p_one) else $error("answer too long");
   property p_cause;
      !avs_waitrequest_out |-> $past(avs_read_in || avs_write_in);
   endproperty
   a_cause: assert property (p_cause) else $error("answer without access");
   property p_rdat;
      $changed(avs_readdata_out) |-> !avs_waitrequest_out && $past(avs_read_in);
   endproperty
   a_rdat: assert property (p_rdat) else $error("read data moved");
   property p_hold;
      tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
   endproperty
   a_hold: assert property (p_hold) else $error("reply byte dropped");
   property p_busy;
      tx_valid_out |-> !rx_ready_out;
   endproperty
   a_busy: assert property (p_busy) else $error("input open while replying");
   property p_first;
      fresh && tx_valid_out |-> tx_data_out inside {8'h42, 8'h45, 8'h3e};
   endproperty
   a_first: assert property (p_first) else $error("bad reply start");
   property p_text;
      tx_valid_out |-> tx_data_out inside {[8'h20:8'h7e], 8'h0d, 8'h0a};
   endproperty
   a_text: assert property (p_text) else $error("unprintable reply byte");
   property p_last;
      tx_valid_out && tx_ready_in && tx_data_out == 8'h3e |=> !tx_valid_out;
   endproperty
   a_last: assert property (p_last) else $error("bytes after prompt");
endmodule
bind btoc_cmd btoc_cmd_props u_props (.clk_in, .rst_b_in, .avs_read_in, .avs_write_in,
   .avs_readdata_out, .avs_waitrequest_out, .rx_data_in, .rx_valid_in, .rx_ready_out,
   .tx_data_out, .tx_valid_out, .tx_ready_in);

/* File: btoc_cmd_test.sv */
// self-checking bench for the bias trim offset command handler
module btoc_cmd_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, rst_b_in, rd, wr, rx_valid, rx_ready, tx_valid, tx_ready, irq, wreq;
   logic [7:0] adr, rx_data, tx_data;
   logic [31:0] wd, rdata, q;
   logic [31:0] tr [9];
   int fails = 0;
   int n_tests = 0;
   string bad [3] = '{"q 1\015", "b,5\015", "b 1,q\015"};
   btoc_cmd uut (.clk_in, .rst_b_in, .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
      .rx_ready_out(rx_ready), .tx_data_out(tx_data), .tx_valid_out(tx_valid),
      .tx_ready_in(tx_ready), .irq_out(irq));
   btoc_host h (.clk_in, .rx_data_out(rx_data), .rx_valid_out(rx_valid),
      .rx_ready_in(rx_ready), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
      .tx_ready_out(tx_ready));
   // ===
   // tasks
   task automatic conclude;
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t value %h expected %h", $time, g, e);
      end
   endtask
   task automatic chks(input string g, e);
      n_tests++;
      if (g != e) begin
         fails++;
         $display("[FAIL] %0t reply mismatch", $time);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk_in); while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rrd(input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   function automatic string show(int f, int n);
      string s = "BIAS TRIM OFFSET:\015\n", sn = "gai", ax = "xyz";
      for (int k = f; k < f + n; k++)
         s = $sformatf("%s%c%c = %08h\015\n", s, sn[k / 3], ax[k % 3], tr[k]);
      return s;
   endfunction
   task automatic cmd(input string s, e);
      h.got = "";
      h.send(s);
      repeat (3000) begin
         if (h.got.len() > 0 && h.got[h.got.len() - 1] == ">")
            break;
         @(posedge clk_in);
      end
      chks(h.got, e);
   endtask
   // ===
   // clock, watchdog, tests
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      fails++;
      conclude();
   end
   initial begin
      rst_b_in = 1'b0;
      {rd, wr, adr, wd} = '0;
      repeat (10) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      rrd(8'h00, 32'h1);
      rrd(8'hfc, 32'h0);
      acc(1'b1, 8'h0c, 32'h7);
      for (int k = 0; k < 9; k++)
         tr[k] = 32'h5;
      cmd("b 5\015", {show(0, 9), ">"});
      for (int k = 0; k < 9; k++)
         rrd(8'h40 + 8'(4 * k), tr[k]);
      chk({31'h0, irq}, 32'h1);
      acc(1'b1, 8'h08, 32'h7);
      repeat (2) @(posedge clk_in);
      chk({31'h0, irq}, 32'h0);
      h.slow = 1'b1;
      for (int k = 3; k < 6; k++)
         tr[k] = 32'hfffffffd;
      cmd("b -3,a\015", {show(3, 3), ">"});
      tr[8] = 32'h7;
      cmd("b 2,i,z\015", {show(8, 1), ">"});
      tr[4] = 32'hfffffffc;
      cmd("b -1,a,y\015", {show(4, 1), ">"});
      tr[0] = 32'h000f4240;
      cmd("b 2000000,g,x\015", {show(0, 1), "E008\015\n>"});
      tr[6] = 32'hfff0bdc0;
      cmd("b -2000000,i,x\015", {show(6, 1), "E008\015\n>"});
      rrd(8'h14, 32'h8);
      rrd(8'h04, 32'h3);
      cmd("b 43639,r\015", {show(0, 0), "rf = 0000aa77\015\n>"});
      rrd(8'h10, 32'h0000aa77);
      acc(1'b1, 8'h0c, 32'h0);
      for (int e = 1; e < 4; e++) begin
         cmd(bad[e - 1], $sformatf("E00%0d\015\n>", e));
         rrd(8'h14, 32'(e));
      end
      acc(1'b0, 8'h04, 32'h0);
      chk({31'h0, q[2]}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      for (int k = 0; k < 9; k++)
         rrd(8'h40 + 8'(4 * k), tr[k]);
      conclude();
   end
endmodule

/* File: btoc_consts.svh */
// constants for the bias trim offset command handler
`ifndef BTOC_CONSTS_SVH
`define BTOC_CONSTS_SVH

// =====================================================================
// register byte offsets
`define BTOC_OFS_CTRL 8'h00
`define BTOC_OFS_STAT 8'h04
`define BTOC_OFS_CLR 8'h08
`define BTOC_OFS_IEN 8'h0c
`define BTOC_OFS_REF 8'h10
`define BTOC_OFS_LERR 8'h14
`define BTOC_OFS_LO_BASE 4'h2
`define BTOC_OFS_HI_BASE 4'h3
`define BTOC_OFS_TRIM_BASE 2'h1

// =====================================================================
// field positions and reset values
`define BTOC_CTRL_EN_BIT 0
`define BTOC_CTRL_RST 1'b1
`define BTOC_ST_DONE_BIT 0
`define BTOC_ST_CLAMP_BIT 1
`define BTOC_ST_ERR_BIT 2
`define BTOC_LIM_LO_RST 32'hfff0bdc0
`define BTOC_LIM_HI_RST 32'h000f4240

// =====================================================================
// ascii characters
`define BTOC_CH_CMD 8'h62
`define BTOC_CH_SP 8'h20
`define BTOC_CH_COMMA 8'h2c
`define BTOC_CH_CR 8'h0d
`define BTOC_CH_LF 8'h0a
`define BTOC_CH_MINUS 8'h2d
`define BTOC_CH_GYRO 8'h67
`define BTOC_CH_ACC 8'h61
`define BTOC_CH_INC 8'h69
`define BTOC_CH_REF 8'h72
`define BTOC_CH_REF2 8'h66
`define BTOC_CH_X 8'h78
`define BTOC_CH_Y 8'h79
`define BTOC_CH_Z 8'h7a
`define BTOC_CH_EQ 8'h3d
`define BTOC_CH_ZERO 8'h30
`define BTOC_CH_NINE 8'h39
`define BTOC_CH_E 8'h45
`define BTOC_CH_PROMPT 8'h3e
`define BTOC_CH_HEXA 8'h57
`define BTOC_HDR_TXT "BIAS TRIM OFFSET:"
`define BTOC_HDR_LEN 5'd17

// =====================================================================
// error codes and response positions
`define BTOC_E_NONE 4'h0
`define BTOC_E_UNKNOWN 4'h1
`define BTOC_E_NARGS 4'h2
`define BTOC_E_PARAM 4'h3
`define BTOC_E_CLAMP 4'h8
`define BTOC_HDR_LAST 5'd18
`define BTOC_LINE_LAST 5'd14
`define BTOC_HEX_LAST 5'd12
`define BTOC_ERR_LAST 5'd5
`define BTOC_REF_IDX 4'd9
`define BTOC_NUM_AXES 9

`endif

/* File: btoc_host.sv */
// host model sending command lines and taking replies
module btoc_host (
   // clock
   input wire logic clk_in,
   // command bytes
   output logic [7:0] rx_data_out,
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   // reply bytes
   input wire logic [7:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   string got = "";
   bit slow = 1'b0;
   logic [1:0] cnt = 2'h0;
   initial begin
      rx_data_out = 8'h00;
      rx_valid_out = 1'b0;
      tx_ready_out = 1'b0;
   end
   // ===
   // one byte per handshake, integer values, one-letter selectors
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         rx_data_out <= s[i];
         rx_valid_out <= 1'b1;
         do @(posedge clk_in); while (rx_ready_in !== 1'b1);
      end
      rx_valid_out <= 1'b0;
      rx_data_out <= ~s[s.len() - 1];
   endtask
   // reply sink, stalls three cycles of four when slow
   always @(posedge clk_in) begin
      if (tx_valid_in && tx_ready_out)
         got = $sformatf("%s%c", got, tx_data_in);
      cnt <= cnt + 2'h1;
      tx_ready_out <= !slow || cnt == 2'h3;
   end
endmodule

/* File: btoc_pkg.sv */
// types for the bias trim offset command handler
package btoc_pkg;

   // =====================================================================
   // parser states
   typedef enum logic [2:0] {
      PS_CMD, PS_SP, PS_NUM, PS_SEL, PS_AXIS, PS_SKIP, PS_EXEC, PS_RSP
   } btoc_state_type;

   // =====================================================================
   // response phases
   typedef enum logic [2:0] {
      RS_HDR, RS_LINE, RS_ERR, RS_PROMPT, RS_DONE
   } btoc_rsp_type;

endpackage
